// ==== boot_mode_stream_config.sv ====
// boot-time mode stream loader with the system-bus write sequencer it steers.
// assumes all inputs synchronous to ref_clk; the stream source shifts one bit
// per mode clock period and the bus agent signals readiness on write_accept_n.
//
// Overview of operation
// - bit 11 low routes timer onto line five
// - bit 12 picks 64-bit or 32-bit bus
// - bits 14:13 set output drive strength
// - bits 17:15 insert 0-7 gap cycles
// - gap applies to block and single writes
// - gap 000 puts data right after address
// - bit 19 sets fast-multiply reset value
// - bits 25:26 readable in config 21:20
// - PLL multiplies bus clock by 2..8
// - single byte-to-width and eight-word block writes
// - block beats 4 or 8; narrow splits
// - reissue mode repeats a write if agent not ready at address
// - pipelined mode allows one write after deassert
// - one stream bit per 256 bus clocks
// - bits 10:9 select non-block write protocol
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module boot_mode_stream_config
    import boot_mode_pkg::*;
(
    input  wire logic        ref_clk,        // bus clock, 250 MHz
    input  wire logic        rst,            // async reset, restarts capture
    input  wire logic        clkEn,          // freezes all state when low
    input  wire logic        modeIn,         // serial mode stream bit
    output logic             modeClock,      // stream shift clock out
    output logic             configDone,     // settings captured and valid
    output logic             modeError,      // reserved code or bit seen
    output mode_settings_t   settings,       // captured settings
    output logic [3:0]       pllMultiplier,  // pipeline to bus clock ratio
    output logic             mulExtraCycle,  // slow multiply in effect
    input  wire logic        timerIrq,       // internal timer event
    input  wire logic [5:0]  extIrq,         // external interrupt lines
    output logic [5:0]       irqLines,       // merged interrupt lines
    input  wire logic        wrReq,          // write request held until taken
    input  wire logic        wrBlock,        // request is a block write
    input  wire logic [3:0]  wrBytes,        // single write size, 1..8
    input  wire logic [31:0] wrAddr,         // write address
    input  wire logic [63:0] wrData,         // data for the current beat
    input  wire logic        write_accept_n, // agent ready, active low
    output logic             wrTaken,        // request accepted pulse
    output logic             dataTake,       // wrData consumed pulse
    output bus_cycle_t       mux_addr_data_bus, // bus cycle out
    input  wire logic [7:0]  regAddr,        // register byte address
    input  wire logic [31:0] regWrData,      // register write data
    input  wire logic        regWr,          // write strobe
    input  wire logic        regRd,          // read strobe
    output logic [31:0]      regRdData       // read data, next cycle
);

    // ==============================================================
    // functions
    function automatic logic fastMode(input logic [1:0] m);
        fastMode = (m == WRM_PIPE) || (m == WRM_REISSUE);
    endfunction : fastMode

    function automatic logic [3:0] beatsFor(input logic blk, input logic narrow);
        beatsFor = blk ? (narrow ? BLOCK_BEATS_NARROW : BLOCK_BEATS_WIDE) : 4'h1;
    endfunction : beatsFor

    // ==============================================================
    // stream capture state
    logic                    capActive_r;
    logic [7:0]              divCnt_r;
    logic [8:0]              bitIdx_r;
    logic [CAPTURE_BITS-1:0] shift_r;
    logic                    rsvdSeen_r;
    logic                    modeClock_r;
    logic                    configDone_r;
    logic                    modeError_r;
    mode_settings_t          settings_r;
    logic [3:0]              pllMult_r;
    logic                    fastMulOff_r;

    wire logic sampleNow  = capActive_r && (divCnt_r == DIV_SAMPLE);
    wire logic lastSample = sampleNow && (bitIdx_r == STREAM_LAST);
    wire logic tailBit    = sampleNow && (bitIdx_r >= POS_RSVD_TAIL) && modeIn;
    wire logic [CAPTURE_BITS-1:0] shiftNxt = {modeIn, shift_r[CAPTURE_BITS-1:1]};

    wire logic rsvdLow = shift_r[POS_RSVD18] || (|shift_r[POS_RSVD_HI:POS_RSVD_LO]);

    mode_settings_t decoded;
    assign decoded.timerRouteOff = shift_r[POS_TIMER];
    assign decoded.narrowBus     = shift_r[POS_WIDTH];
    assign decoded.drvStrength   = shift_r[POS_DRV+1:POS_DRV];
    assign decoded.writeGap      = shift_r[POS_GAP+2:POS_GAP];
    assign decoded.mulSlow       = shift_r[POS_FASTMUL];
    // identifier, bit 25 lands in 21
    assign decoded.sysIdent      = {shift_r[POS_IDENT], shift_r[POS_IDENT+1]};
    assign decoded.wrMode        = shift_r[POS_WRMODE+1:POS_WRMODE];
    assign decoded.pllRatio      = shift_r[POS_RATIO+2:POS_RATIO];

    wire logic decodeBad = rsvdLow || rsvdSeen_r || tailBit || (decoded.wrMode == WRM_RESERVED)
                           || (decoded.pllRatio == RATIO_RSVD);

    // ==============================================================
    // stream sequencer
    // one bit per divider period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capActive_r <= 1'b1;
            divCnt_r    <= '0;
            bitIdx_r    <= '0;
            modeClock_r <= 1'b0;
        end else if (clkEn && capActive_r) begin
            divCnt_r    <= divCnt_r + 8'h01;
            modeClock_r <= (divCnt_r == DIV_SAMPLE) ? 1'b0 : ((divCnt_r == DIV_LAST) ? 1'b1 : modeClock_r);
            if (divCnt_r == DIV_LAST) begin
                bitIdx_r <= bitIdx_r + 9'h001;
            end
            if (lastSample) begin
                capActive_r <= 1'b0;
                modeClock_r <= 1'b0;
            end
        end
    end

    // bit 0 first, held after capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_r    <= '0;
            rsvdSeen_r <= 1'b0;
        end else if (clkEn && sampleNow) begin
            if (bitIdx_r < CAPTURE_END) begin
                shift_r <= shiftNxt;
            end
            if (tailBit) begin
                rsvdSeen_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            settings_r   <= SETTINGS_RESET;
            configDone_r <= 1'b0;
            modeError_r  <= 1'b0;
            pllMult_r    <= RATIO_BASE;
        end else if (clkEn && lastSample) begin
            settings_r   <= decoded;
            configDone_r <= 1'b1;
            modeError_r  <= decodeBad;
            pllMult_r    <= {1'b0, decoded.pllRatio} + RATIO_BASE;
        end
    end

    // ==============================================================
    // register port
    wire logic cfgWrite = regWr && (regAddr == REG_PROC_CONFIG);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fastMulOff_r <= 1'b0;
        end else if (clkEn) begin
            if (lastSample) begin
                fastMulOff_r <= decoded.mulSlow;
            end else if (cfgWrite && configDone_r) begin
                fastMulOff_r <= regWrData[CFG_FASTMUL_BIT];
            end
        end
    end

    logic [31:0] cfgWord;
    logic [31:0] statWord;
    logic [31:0] rdSel;
    logic        wrBusy;

    always_comb begin
        cfgWord = RD_ZERO;
        cfgWord[CFG_FASTMUL_BIT] = fastMulOff_r;
        cfgWord[CFG_IDENT_LSB+1:CFG_IDENT_LSB] = settings_r.sysIdent;
        statWord = RD_ZERO;
        statWord[STAT_DONE_BIT] = configDone_r;
        statWord[STAT_ERR_BIT]  = modeError_r;
        statWord[STAT_BUSY_BIT] = wrBusy;
    end

    assign rdSel = (regAddr == REG_PROC_CONFIG) ? cfgWord :
                   (regAddr == REG_MODE_LOW)    ? shift_r :
                   (regAddr == REG_STATUS)      ? statWord : RD_ZERO;

    logic [31:0] regRdData_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData_r <= RD_ZERO;
        end else if (clkEn) begin
            regRdData_r <= regRd ? rdSel : RD_ZERO;
        end
    end

    // ==============================================================
    // interrupt merge
    logic [5:0] irq_r;
    wire logic [5:0] irqNxt = extIrq | {timerIrq && !settings_r.timerRouteOff && configDone_r, 5'h00};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_r <= '0;
        end else if (clkEn) begin
            irq_r <= irqNxt;
        end
    end

    // ==============================================================
    // write sequencer
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_GAP, ST_DATA} wr_state_t;
    wr_state_t   state_r;
    wr_state_t   stateNxt;
    logic [2:0]  gapCnt_r;
    logic [3:0]  beat_r;
    logic [3:0]  beatsTot_r;
    logic        splitPend_r;
    logic        missed_r;
    logic        extraUsed_r;
    logic [31:0] addr_r;
    logic        blk_r;
    bus_cycle_t  bus_r;
    logic        wrTaken_r;
    logic        dataTake_r;

    wire logic narrow    = settings_r.narrowBus;
    wire logic [1:0] wrm = settings_r.wrMode;
    wire logic agentRdy  = !write_accept_n;
    wire logic pipeExtra = (wrm == WRM_PIPE) && !extraUsed_r;
    wire logic canIssue  = configDone_r && (agentRdy || pipeExtra);
    // narrow single above four bytes splits
    wire logic needSplit = narrow && !wrBlock && (wrBytes > NARROW_BYTES);
    wire logic lastBeat  = (state_r == ST_DATA) && (beat_r + 4'h1 == beatsTot_r);
    wire logic chainOk   = lastBeat && !splitPend_r && !missed_r && fastMode(wrm) && !blk_r;
    wire logic acceptNow = wrReq && canIssue && ((state_r == ST_IDLE) || chainOk);
    wire logic reissue   = lastBeat && missed_r && (wrm == WRM_REISSUE);
    assign wrBusy = (state_r != ST_IDLE);

    always_comb begin
        stateNxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (acceptNow) begin
                    stateNxt = ST_ADDR;
                end
            end
            // zero gap goes straight to data
            ST_ADDR: begin
                stateNxt = (settings_r.writeGap == 3'h0) ? ST_DATA : ST_GAP;
            end
            ST_GAP: begin
                if (gapCnt_r == 3'h1) begin
                    stateNxt = ST_DATA;
                end
            end
            ST_DATA: begin
                if (lastBeat) begin
                    stateNxt = (splitPend_r || reissue || acceptNow) ? ST_ADDR : ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            gapCnt_r    <= '0;
            beat_r      <= '0;
            beatsTot_r  <= 4'h1;
            splitPend_r <= 1'b0;
            missed_r    <= 1'b0;
            addr_r      <= '0;
            blk_r       <= 1'b0;
        end else if (clkEn) begin
            state_r <= stateNxt;
            if (acceptNow) begin
                addr_r      <= wrAddr;
                blk_r       <= wrBlock;
                beatsTot_r  <= beatsFor(wrBlock, narrow);
                splitPend_r <= needSplit;
            end else if (lastBeat && splitPend_r) begin
                addr_r      <= addr_r + NARROW_ADDR_STEP;
                splitPend_r <= 1'b0;
            end
            if (state_r == ST_ADDR) begin
                gapCnt_r <= settings_r.writeGap;
                missed_r <= (wrm == WRM_REISSUE) && !agentRdy;
                beat_r   <= '0;
            end else if (state_r == ST_GAP) begin
                gapCnt_r <= gapCnt_r - 3'h1;
            end else if (state_r == ST_DATA) begin
                beat_r <= beat_r + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            extraUsed_r <= 1'b0;
        end else if (clkEn) begin
            if (agentRdy) begin
                extraUsed_r <= 1'b0;
            end else if (acceptNow) begin
                extraUsed_r <= 1'b1;
            end
        end
    end

    // ==============================================================
    // registered bus outputs
    wire logic [31:0] addrNxt = acceptNow ? wrAddr : (splitPend_r ? addr_r + NARROW_ADDR_STEP : addr_r);
    // narrow bus carries the low word; a split's high half is patched at the output flop
    wire logic [63:0] dataNxt = narrow ? {32'h0000_0000, wrData[31:0]} : wrData;

    bus_cycle_t busNxt;
    always_comb begin
        busNxt.addrCycle = (stateNxt == ST_ADDR);
        busNxt.dataCycle = (stateNxt == ST_DATA);
        busNxt.beatIdx   = ((state_r == ST_DATA) && (stateNxt == ST_DATA)) ? beat_r + 4'h1 : 4'h0;
        busNxt.word      = 64'h0000_0000_0000_0000;
        if (stateNxt == ST_ADDR) begin
            busNxt.word = {32'h0000_0000, addrNxt};
        end else if (stateNxt == ST_DATA) begin
            busNxt.word = dataNxt;
        end
    end

    logic splitSecond_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_r         <= '0;
            wrTaken_r     <= 1'b0;
            dataTake_r    <= 1'b0;
            splitSecond_r <= 1'b0;
        end else if (clkEn) begin
            bus_r      <= busNxt;
            wrTaken_r  <= acceptNow;
            dataTake_r <= (stateNxt == ST_DATA);
            if (acceptNow) begin
                splitSecond_r <= 1'b0;
            end else if (lastBeat && splitPend_r) begin
                splitSecond_r <= 1'b1;
            end
            if (splitSecond_r && (stateNxt == ST_DATA)) begin
                bus_r.word <= {32'h0000_0000, wrData[63:32]};
            end
        end
    end

    // ==============================================================
    // outputs
    assign modeClock         = modeClock_r;
    assign configDone        = configDone_r;
    assign modeError         = modeError_r;
    assign settings          = settings_r;
    assign pllMultiplier     = pllMult_r;
    assign mulExtraCycle     = fastMulOff_r;
    assign irqLines          = irq_r;
    assign wrTaken           = wrTaken_r;
    assign dataTake          = dataTake_r;
    assign mux_addr_data_bus = bus_r;
    assign regRdData         = regRdData_r;

endmodule : boot_mode_stream_config

`default_nettype wire

// ==== boot_mode_pkg.sv ====
// package for the boot-time mode stream loader: stream layout, register map,
// write-sequencer figures and the carrier structs.
// assumes a single 250 MHz bus clock domain.
package boot_mode_pkg;

    // ==============================================================
    // serial stream timing
    localparam int MODE_BIT_CYCLES = 256;
    localparam int STREAM_BITS     = 257;
    localparam int CAPTURE_BITS    = 32;
    localparam logic [7:0] DIV_LAST    = 8'(MODE_BIT_CYCLES - 1);
    localparam logic [7:0] DIV_SAMPLE  = 8'(MODE_BIT_CYCLES / 2 - 1);
    localparam logic [8:0] STREAM_LAST = 9'(STREAM_BITS - 1);
    localparam logic [8:0] CAPTURE_END = 9'(CAPTURE_BITS);

    // ==============================================================
    // stream bit positions
    localparam int POS_RATIO    = 5;
    localparam int POS_WRMODE   = 9;
    localparam int POS_TIMER    = 11;
    localparam int POS_WIDTH    = 12;
    localparam int POS_DRV      = 13;
    localparam int POS_GAP      = 15;
    localparam int POS_RSVD18   = 18;
    localparam int POS_FASTMUL  = 19;
    localparam int POS_RSVD_LO  = 20;
    localparam int POS_RSVD_HI  = 24;
    localparam int POS_IDENT    = 25;
    localparam logic [8:0] POS_RSVD_TAIL = 9'h01B;

    // ==============================================================
    // field encodings
    localparam logic [1:0] WRM_LEGACY   = 2'h0;
    localparam logic [1:0] WRM_RESERVED = 2'h1;
    localparam logic [1:0] WRM_PIPE     = 2'h2;
    localparam logic [1:0] WRM_REISSUE  = 2'h3;
    localparam logic [2:0] RATIO_RSVD   = 3'h7;
    localparam logic [3:0] RATIO_BASE   = 4'h2;

    // ==============================================================
    // bus write sequencing
    localparam logic [3:0] BLOCK_BEATS_WIDE   = 4'h4;
    localparam logic [3:0] BLOCK_BEATS_NARROW = 4'h8;
    localparam logic [3:0] NARROW_BYTES       = 4'h4;
    localparam logic [31:0] NARROW_ADDR_STEP  = 32'h0000_0004;

    // ==============================================================
    // register map
    localparam logic [7:0] REG_PROC_CONFIG = 8'h00;
    localparam logic [7:0] REG_MODE_LOW    = 8'h04;
    localparam logic [7:0] REG_STATUS      = 8'h08;
    localparam int CFG_FASTMUL_BIT = 0;
    localparam int CFG_IDENT_LSB   = 20;
    localparam int STAT_DONE_BIT   = 0;
    localparam int STAT_ERR_BIT    = 1;
    localparam int STAT_BUSY_BIT   = 2;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ==============================================================
    // carriers
    typedef struct packed {
        logic       timerRouteOff;
        logic       narrowBus;
        logic [1:0] drvStrength;
        logic [2:0] writeGap;
        logic       mulSlow;
        logic [1:0] sysIdent;
        logic [1:0] wrMode;
        logic [2:0] pllRatio;
    } mode_settings_t;

    localparam mode_settings_t SETTINGS_RESET = '0;

    typedef struct packed {
        logic        addrCycle;
        logic        dataCycle;
        logic [3:0]  beatIdx;
        logic [63:0] word;
    } bus_cycle_t;

endpackage : boot_mode_pkg

// ==== mode_stream_source.sv ====
// far-side model: serial boot stream source feeding the loader.
// assumes it leaves reset together with the loader and clkEn stays high.
`timescale 1ns/100ps
`default_nettype none

module mode_stream_source
    import boot_mode_pkg::*;
#(
    parameter logic [31:0] LOW_BITS = 32'h0009_5460 // stream bits 31:0
)(
    input  wire logic ref_clk, // bus clock
    input  wire logic rst,     // active high
    output logic      modeIn   // serial stream bit
);
    logic [16:0] cycleCnt_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            cycleCnt_r <= '0;
        else if (cycleCnt_r != 17'h1FFFF)
            cycleCnt_r <= cycleCnt_r + 17'h1;
    end

    // bit per 256, zeros, bit19 set
    assign modeIn = (cycleCnt_r[16:8] < 9'h020) ? LOW_BITS[cycleCnt_r[12:8]] : 1'h0;
endmodule : mode_stream_source
`default_nettype wire

// ==== boot_mode_checker_properties.sv ====
// checker for the stream loader: settings, interrupt merge, write framing.
// assumes it is bound to the loader and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module boot_mode_checker
    import boot_mode_pkg::*;
(
    input wire logic           ref_clk,           // bus clock
    input wire logic           rst,               // async reset
    input wire logic           configDone,        // capture complete
    input wire logic           modeClock,         // stream clock
    input wire mode_settings_t settings,          // captured settings
    input wire logic [3:0]     pllMultiplier,     // clock ratio
    input wire logic           mulExtraCycle,     // slow multiply
    input wire logic           timerIrq,          // timer event
    input wire logic [5:0]     extIrq,            // external lines
    input wire logic [5:0]     irqLines,          // merged lines
    input wire logic           wrTaken,           // request taken
    input wire logic           dataTake,          // data consumed
    input wire bus_cycle_t     mux_addr_data_bus  // bus cycle
);
    wire addrC = mux_addr_data_bus.addrCycle;
    wire dataC = mux_addr_data_bus.dataCycle;
    logic [3:0] idleCnt_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // idle cycles since the last bus cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            idleCnt_r <= '0;
        else if (addrC || dataC)
            idleCnt_r <= '0;
        else if (idleCnt_r != 4'hF)
            idleCnt_r <= idleCnt_r + 4'h1;
    end

    property p_gap;
        dataC && !$past(dataC) |-> idleCnt_r == {1'h0, settings.writeGap};
    endproperty
    a_gap: assert property (p_gap) else $error("write gap wrong");
    property p_timer;
        configDone && !settings.timerRouteOff |=> irqLines[5] == ($past(timerIrq) || $past(extIrq[5]));
    endproperty
    a_timer: assert property (p_timer) else $error("timer route wrong");
    property p_mult;
        configDone |-> pllMultiplier == {1'h0, settings.pllRatio} + 4'h2;
    endproperty
    a_mult: assert property (p_mult) else $error("pll ratio wrong");
    property p_hold;
        configDone && $past(configDone) |-> $stable(settings) && $stable(pllMultiplier);
    endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_done;
        configDone |=> configDone[*8];
    endproperty
    a_done: assert property (p_done) else $error("done dropped");
    property p_taken;
        wrTaken |-> addrC;
    endproperty
    a_taken: assert property (p_taken) else $error("taken without address");
    property p_take;
        dataTake == dataC;
    endproperty
    a_take: assert property (p_take) else $error("data take mismatch");
    property p_idle;
        !configDone |-> !addrC && !dataC;
    endproperty
    a_idle: assert property (p_idle) else $error("bus active early");
    property p_mclk;
        configDone |-> !modeClock && (!$rose(configDone) || mulExtraCycle == settings.mulSlow);
    endproperty
    a_mclk: assert property (p_mclk) else $error("stream clock after capture");
endmodule : boot_mode_checker

bind boot_mode_stream_config boot_mode_checker chk (.ref_clk, .rst, .configDone, .modeClock, .settings,
    .pllMultiplier, .mulExtraCycle, .timerIrq, .extIrq, .irqLines, .wrTaken, .dataTake, .mux_addr_data_bus);
`default_nettype wire

// ==== tb_boot_mode_stream_config.sv ====
// testbench: capture, registers, interrupt merge, narrow-bus writes.
// assumes the stream model and the bound checker.
`timescale 1ns/100ps
`default_nettype none

module tb_boot_mode_stream_config import boot_mode_pkg::*;;
    logic           ref_clk, rst, clkEn, timerIrq, wrReq, wrBlock, write_accept_n, regWr, regRd;
    logic           modeIn, modeClock, configDone, modeError, mulExtraCycle, wrTaken, dataTake;
    logic [5:0]     extIrq, irqLines;
    logic [3:0]     wrBytes, pllMultiplier;
    logic [31:0]    wrAddr, regWrData, regRdData;
    logic [63:0]    wrData;
    logic [7:0]     regAddr;
    mode_settings_t settings;
    bus_cycle_t     mux_addr_data_bus;
    logic [36:0]    evQ[$];
    logic [3:0]     idle = 4'h0;
    int             n_errors = 0, checks_done = 0, i;

    mode_stream_source src (.ref_clk, .rst, .modeIn);
    boot_mode_stream_config dut (.ref_clk, .rst, .clkEn, .modeIn, .modeClock, .configDone, .modeError,
        .settings, .pllMultiplier, .mulExtraCycle, .timerIrq, .extIrq, .irqLines, .wrReq, .wrBlock, .wrBytes,
        .wrAddr, .wrData, .write_accept_n, .wrTaken, .dataTake, .mux_addr_data_bus, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData);

    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // log of bus cycles with idle count before each data cycle
    always @(posedge ref_clk) begin
        if (mux_addr_data_bus.addrCycle === 1'h1) begin
            evQ.push_back({1'h0, 4'h0, mux_addr_data_bus.word[31:0]});
            idle = 4'h0;
        end else if (mux_addr_data_bus.dataCycle === 1'h1) begin
            evQ.push_back({1'h1, idle, mux_addr_data_bus.word[31:0]});
            idle = 4'h0;
        end else
            idle = idle + 4'h1;
    end

    task automatic check(input string what, input logic [63:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : check

    task automatic ev(input logic dc, input logic [3:0] g, input logic [31:0] w);
        check("bus cycle", {dc, g, w}, (evQ.size() != 0) ? evQ.pop_front() : 37'hX);
    endtask : ev

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge ref_clk);
        regWr <= 1'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge ref_clk);
        regRd <= 1'h0;
        #1 check("regRdData", e, regRdData);
    endtask : reg_rd

    task automatic wr(input logic b, input logic [3:0] n, input logic [31:0] a, input logic [63:0] d,
                      input int lim, input logic expTaken);
        @(posedge ref_clk);
        {wrReq, wrBlock, wrBytes, wrAddr, wrData} <= {1'h1, b, n, a, d};
        for (i = 0; i < lim && wrTaken !== 1'h1; i++)
            @(posedge ref_clk) #1;
        check("wrTaken", expTaken, wrTaken);
        @(posedge ref_clk);
        wrReq <= 1'h0;
        repeat (30) @(posedge ref_clk);
    endtask : wr

    task automatic note(input string t);
        $display("test %s finished", t);
    endtask : note

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (80000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        {rst, clkEn, timerIrq, wrReq, wrBlock, write_accept_n, regWr, regRd} = 8'hC0;
        {extIrq, wrBytes, wrAddr, wrData, regAddr, regWrData} = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        reg_rd(8'h08, 32'h0);
        wr(1'h0, 4'h4, 32'h100, 64'h0, 20, 1'h0);
        check("bus idle", 0, evQ.size());
        for (i = 0; i < 70000 && configDone !== 1'h1; i++)
            @(posedge ref_clk);
        #1 check("settings", 15'h3293, settings);
        check("pllMultiplier", 4'h5, pllMultiplier);
        check("mulExtraCycle", 1'h1, mulExtraCycle);
        check("modeError", 1'h0, modeError);
        note("capture");
        reg_rd(8'h04, 32'h0009_5460);
        reg_rd(8'h00, 32'h1);
        reg_rd(8'h08, 32'h1);
        reg_rd(8'h0C, 32'h0);
        reg_wr(8'h04, 32'hFFFF_FFFF);
        reg_wr(8'h00, 32'h0030_0000);
        reg_rd(8'h00, 32'h0);
        check("mulExtraCycle", 1'h0, mulExtraCycle);
        reg_rd(8'h04, 32'h0009_5460);
        note("registers");
        @(posedge ref_clk);
        extIrq <= 6'h05;
        timerIrq <= 1'h1;
        repeat (2) @(posedge ref_clk);
        #1 check("irqLines", 6'h25, irqLines);
        @(posedge ref_clk);
        clkEn <= 1'h0;
        extIrq <= 6'h00;
        repeat (3) @(posedge ref_clk);
        #1 check("irqLines frozen", 6'h25, irqLines);
        @(posedge ref_clk);
        clkEn <= 1'h1;
        note("interrupts");
        wr(1'h1, 4'h8, 32'h1000, 64'hA5A5_0001_1234_5678, 40, 1'h1);
        ev(1'h0, 4'h0, 32'h1000);
        ev(1'h1, 4'h2, 32'h1234_5678);
        for (int k = 1; k < 8; k++)
            ev(1'h1, 4'h0, 32'h1234_5678);
        check("bus idle", 0, evQ.size());
        wr(1'h0, 4'h8, 32'h2000, 64'h0BAD_F00D_C0DE_0001, 40, 1'h1);
        ev(1'h0, 4'h0, 32'h2000);
        ev(1'h1, 4'h2, 32'hC0DE_0001);
        ev(1'h0, 4'h0, 32'h2004);
        ev(1'h1, 4'h2, 32'h0BAD_F00D);
        wr(1'h0, 4'h2, 32'h3002, 64'hBEEF, 40, 1'h1);
        ev(1'h0, 4'h0, 32'h3002);
        ev(1'h1, 4'h2, 32'hBEEF);
        note("writes");
        @(posedge ref_clk);
        write_accept_n <= 1'h1;
        wr(1'h0, 4'h4, 32'h4000, 64'h44, 40, 1'h1);
        wr(1'h0, 4'h4, 32'h5000, 64'h55, 20, 1'h0);
        @(posedge ref_clk);
        write_accept_n <= 1'h0;
        wr(1'h0, 4'h4, 32'h5000, 64'h55, 40, 1'h1);
        ev(1'h0, 4'h0, 32'h4000);
        ev(1'h1, 4'h2, 32'h44);
        ev(1'h0, 4'h0, 32'h5000);
        ev(1'h1, 4'h2, 32'h55);
        note("pipelined");
        give_verdict();
    end
endmodule : tb_boot_mode_stream_config
`default_nettype wire
